/* hw/rst_evt_pkg.sv */
// Shared constants, register map and types of the reset-event clearing block
package rst_evt_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register map, byte addresses on the plain register port
    localparam logic [7:0] CFG_A_BASE    = 8'h00;
    localparam logic [7:0] CFG_B_BASE    = 8'h06;
    localparam logic [7:0] SCTRL_BASE    = 8'h08;
    localparam logic [7:0] PWM_BASE      = 8'h10;
    localparam logic [7:0] PSC_BASE      = 8'h18;
    localparam logic [7:0] COMM_BASE     = 8'h20;
    localparam logic [7:0] STATE_ADDR    = 8'h30;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h31;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h32;

    localparam int CFG_A_BYTES = 6;
    localparam int CFG_B_BYTES = 2;
    localparam int SCTRL_BYTES = 2;
    localparam int PWM_BYTES   = 8;
    localparam int PSC_BYTES   = 2;
    localparam int COMM_BYTES  = 6;
    localparam int NUM_CELLS   = 15;

    // Field positions
    localparam int MUTE_BIT      = 1;
    localparam int TMEN_BIT      = 3;
    localparam int TOUT_LSB      = 4;
    localparam int TOUT_W        = 4;
    localparam int GPIO_LSB      = 0;
    localparam int GPIO_W        = 4;
    localparam int IRQ_THSD_BIT  = 0;
    localparam int IRQ_WDT_BIT   = 1;
    localparam int IRQ_DT_BIT    = 2;
    localparam int IRQ_W         = 3;

    // Reset values
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] SCTRL_RST = 8'h00;
    localparam logic [7:0] PWM_RST   = 8'hff;
    localparam logic [7:0] COMM_RST  = 8'hff;
    localparam logic [2:0] MASK_RST  = 3'h0;

    // Timing
    localparam int CLK_HZ         = 20_000_000;
    localparam int WDT_TIMEOUT_MS = 2000;
    localparam int WDT_CYCLES     = WDT_TIMEOUT_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        PS_STANDBY  = 3'b001,
        PS_LONG_DIS = 3'b010,
        PS_SLEEP    = 3'b100
    } power_state_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;

endpackage : rst_evt_pkg

/* hw/sync_2ff.sv */
// Two-flop level synchroniser for pin inputs
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule : sync_2ff

/* hw/timeout_counter.sv */
// Restartable timeout counter with sticky expiry and one-cycle fire pulse
`timescale 1ns/1ps
module timeout_counter #(
    parameter int LIMIT = 40_000_000,
    parameter int W     = $clog2(LIMIT + 1)
) (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic restart_i,
    output logic      expired_o,
    output logic      fire_o
);
    logic [W-1:0] count_reg;

    // Counting stops once expired so fire stays a single pulse
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_reg <= '0;
            expired_o <= 1'b0;
            fire_o    <= 1'b0;
        end else if (restart_i) begin
            count_reg <= '0;
            expired_o <= 1'b0;
            fire_o    <= 1'b0;
        end else if (!expired_o && count_reg == W'(LIMIT - 1)) begin
            count_reg <= '0;
            expired_o <= 1'b1;
            fire_o    <= 1'b1;
        end else begin
            count_reg <= expired_o ? count_reg : count_reg + 1'b1;
            fire_o    <= 1'b0;
        end
    end

    property p_fire_at_limit;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!expired_o && count_reg == W'(LIMIT - 1) && !restart_i) |=> (fire_o && expired_o);
    endproperty
    a_fire_at_limit: assert property (p_fire_at_limit) else $error("missed limit");

    property p_restart_clears;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        restart_i |=> (!expired_o && !fire_o && count_reg == '0);
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart lost");
endmodule : timeout_counter

/* hw/rst_evt_clear.sv */
// Reset-event clearing of configuration, switch-control, modulation and comm groups
//
// Behaviour
// - Power cycle restores defaults, discharge off, standby.
// - Thermal shutdown stops discharge, keeps switch control.
// - Thermal shutdown clears A, B but mute, comm.
// - Watchdog with timer: long discharge, clear A0, comm.
// - Same case clears A1-A3 when monitor disabled.
// - Same case clears GPIO nibble of B0.
// - Watchdog without timer: sleep, clear everything.
// - Timer after watchdog acts like rule seven.
// - Timer before watchdog: discharge off, groups, A4-A5.
// - Same case clears A1-A3 when monitor enabled.
// - Same case clears upper nibble of B0.
// - Same case clears B1 except mute.
// - Watchdog fires after two quiet seconds.
// - Valid matching command restarts the watchdog.
// - Timer runs only with pin high, field nonzero.
`timescale 1ns/1ps
module rst_evt_clear
    import rst_evt_pkg::*;
#(
    parameter int WDT_LIMIT = rst_evt_pkg::WDT_CYCLES
) (
    input  wire logic                          clk_sys_i,
    input  wire logic                          sys_rst_i,
    input  wire rst_evt_pkg::bus_req_s         bus_req_i,
    input  wire logic                          cmd_ok_i,
    input  wire logic                          dt_expire_i,
    input  wire logic                          thsd_pin_i,
    input  wire logic                          discharge_timer_pin_enable_i,
    output logic [rst_evt_pkg::DATA_W-1:0]     rd_data_o,
    output rst_evt_pkg::power_state_e          power_state_o,
    output logic [rst_evt_pkg::NUM_CELLS-1:0]  s_drive_o,
    output logic                               wdt_expired_o,
    output logic                               dt_running_o,
    output logic                               irq_o
);
    import rst_evt_pkg::*;

    logic [7:0]   cfg_a_reg [CFG_A_BYTES];
    logic [7:0]   cfg_b_reg [CFG_B_BYTES];
    logic [7:0]   sctrl_reg [SCTRL_BYTES];
    logic [7:0]   pwm_reg   [PWM_BYTES];
    logic [7:0]   psc_reg   [PSC_BYTES];
    logic [7:0]   comm_reg  [COMM_BYTES];
    logic         dis_en_reg;
    logic         thsd_d_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic         thsd_s;
    logic         pin_en_s;
    logic         wdt_exp;
    logic         wdt_fire;
    logic         wdt_past;
    logic         tme;
    logic         dt_run;
    logic         ev_full;
    logic         ev_long;
    logic         ev_short;
    logic         ev_thsd;
    logic [CFG_A_BYTES-1:0] clr_a;
    logic         clr_b0_lo;
    logic         clr_b0_hi;
    logic         clr_b1_rest;
    logic         clr_b1_mute;
    logic         clr_grp;
    logic         clr_comm;
    logic         dis_off;
    logic [7:0]   off;
    logic [IRQ_W-1:0] irq_set;

    sync_2ff #(
        .W (2)
    ) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({thsd_pin_i, discharge_timer_pin_enable_i}),
        .sync_o    ({thsd_s, pin_en_s})
    );

    timeout_counter #(
        .LIMIT (WDT_LIMIT)
    ) u_wdt (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .restart_i (cmd_ok_i),
        .expired_o (wdt_exp),
        .fire_o    (wdt_fire)
    );

    assign tme    = cfg_b_reg[1][TMEN_BIT];
    assign dt_run = pin_en_s && (cfg_a_reg[5][TOUT_LSB +: TOUT_W] != '0);

    // Event classification; a timer expiry in the same cycle as the watchdog
    // fire sees the watchdog as not yet elapsed
    always_comb begin
        ev_thsd  = thsd_s && !thsd_d_reg;
        wdt_past = wdt_exp && !wdt_fire;
        ev_full  = (wdt_fire && !dt_run) || (dt_expire_i && wdt_past);
        ev_long  = wdt_fire && dt_run;
        ev_short = dt_expire_i && !wdt_past;
        // Masks are the union of every event present this cycle
        clr_a[0] = ev_full || ev_thsd || ev_long;
        for (int i = 1; i <= 3; i++) begin
            clr_a[i] = ev_full || ev_thsd || (tme ? ev_short : ev_long);
        end
        for (int i = 4; i < CFG_A_BYTES; i++) begin
            clr_a[i] = ev_full || ev_thsd || ev_short;
        end
        clr_b0_lo   = ev_full || ev_thsd || ev_long;
        clr_b0_hi   = ev_full || ev_thsd || ev_short;
        clr_b1_rest = ev_full || ev_thsd || ev_short;
        clr_b1_mute = ev_full;
        clr_grp     = ev_full || ev_short;
        clr_comm    = ev_full || ev_thsd || ev_long;
        dis_off     = ev_full || ev_short || ev_thsd;
        irq_set     = '0;
        irq_set[IRQ_THSD_BIT] = ev_thsd;
        irq_set[IRQ_WDT_BIT]  = wdt_fire;
        irq_set[IRQ_DT_BIT]   = dt_expire_i;
    end

    // Configuration groups; a clear beats a host write in the same cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < CFG_A_BYTES; i++) cfg_a_reg[i] <= CFG_RST;
            for (int i = 0; i < CFG_B_BYTES; i++) cfg_b_reg[i] <= CFG_RST;
        end else begin
            for (int i = 0; i < CFG_A_BYTES; i++) begin
                if (clr_a[i]) begin
                    cfg_a_reg[i] <= CFG_RST;
                end else if (bus_req_i.wr && bus_req_i.addr == CFG_A_BASE + 8'(i)) begin
                    cfg_a_reg[i] <= bus_req_i.wdata;
                end
            end
            if (bus_req_i.wr && bus_req_i.addr == CFG_B_BASE) begin
                cfg_b_reg[0] <= bus_req_i.wdata;
            end
            if (clr_b0_lo) begin
                cfg_b_reg[0][GPIO_LSB +: GPIO_W] <= CFG_RST[GPIO_LSB +: GPIO_W];
            end
            if (clr_b0_hi) begin
                cfg_b_reg[0][7:4] <= CFG_RST[7:4];
            end
            for (int b = 0; b < 8; b++) begin
                if (b == MUTE_BIT ? clr_b1_mute : clr_b1_rest) begin
                    cfg_b_reg[1][b] <= CFG_RST[b];
                end else if (bus_req_i.wr && bus_req_i.addr == CFG_B_BASE + 8'h01) begin
                    cfg_b_reg[1][b] <= bus_req_i.wdata[b];
                end
            end
        end
    end

    // Switch-control, modulation and comm groups
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < SCTRL_BYTES; i++) sctrl_reg[i] <= SCTRL_RST;
            for (int i = 0; i < PWM_BYTES; i++)   pwm_reg[i]   <= PWM_RST;
            for (int i = 0; i < PSC_BYTES; i++)   psc_reg[i]   <= PWM_RST;
            for (int i = 0; i < COMM_BYTES; i++)  comm_reg[i]  <= COMM_RST;
        end else begin
            for (int i = 0; i < SCTRL_BYTES; i++) begin
                if (clr_grp) sctrl_reg[i] <= SCTRL_RST;
                else if (bus_req_i.wr && bus_req_i.addr == SCTRL_BASE + 8'(i))
                    sctrl_reg[i] <= bus_req_i.wdata;
            end
            for (int i = 0; i < PWM_BYTES; i++) begin
                if (clr_grp) pwm_reg[i] <= PWM_RST;
                else if (bus_req_i.wr && bus_req_i.addr == PWM_BASE + 8'(i))
                    pwm_reg[i] <= bus_req_i.wdata;
            end
            for (int i = 0; i < PSC_BYTES; i++) begin
                if (clr_grp) psc_reg[i] <= PWM_RST;
                else if (bus_req_i.wr && bus_req_i.addr == PSC_BASE + 8'(i))
                    psc_reg[i] <= bus_req_i.wdata;
            end
            for (int i = 0; i < COMM_BYTES; i++) begin
                if (clr_comm) comm_reg[i] <= COMM_RST;
                else if (bus_req_i.wr && bus_req_i.addr == COMM_BASE + 8'(i))
                    comm_reg[i] <= bus_req_i.wdata;
            end
        end
    end

    // Discharge gate: armed by any switch-control write, dropped by full, short and thermal events and
    // held off while the die is hot
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dis_en_reg <= 1'b0;
            thsd_d_reg <= 1'b0;
            s_drive_o  <= '0;
        end else begin
            thsd_d_reg <= thsd_s;
            if (dis_off || thsd_s) begin
                dis_en_reg <= 1'b0;
            end else if (bus_req_i.wr && bus_req_i.addr >= SCTRL_BASE
                         && bus_req_i.addr < SCTRL_BASE + 8'(SCTRL_BYTES)) begin
                dis_en_reg <= 1'b1;
            end
            s_drive_o <= dis_en_reg ? NUM_CELLS'({sctrl_reg[1], sctrl_reg[0]}) : '0;
        end
    end

    // Power state; events win over a waking command in the same cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            power_state_o <= PS_STANDBY;
        end else begin
            case (power_state_o)
                PS_STANDBY, PS_LONG_DIS, PS_SLEEP: begin
                    if (ev_full) power_state_o <= PS_SLEEP;
                    else if (ev_long) power_state_o <= PS_LONG_DIS;
                    else if (cmd_ok_i) power_state_o <= PS_STANDBY;
                end
                default: power_state_o <= PS_STANDBY;
            endcase
        end
    end

    // Status outputs and interrupts; a new event wins over the read-clear
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat_reg  <= '0;
            irq_mask_reg  <= MASK_RST;
            irq_o         <= 1'b0;
            wdt_expired_o <= 1'b0;
            dt_running_o  <= 1'b0;
        end else begin
            if (bus_req_i.rd && bus_req_i.addr == IRQ_STAT_ADDR) irq_stat_reg <= irq_set;
            else irq_stat_reg <= irq_stat_reg | irq_set;
            if (bus_req_i.wr && bus_req_i.addr == IRQ_MASK_ADDR)
                irq_mask_reg <= bus_req_i.wdata[IRQ_W-1:0];
            irq_o         <= |(irq_stat_reg & irq_mask_reg);
            wdt_expired_o <= wdt_exp;
            dt_running_o  <= dt_run;
        end
    end

    // Read port, data in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        off = '0;
        if (bus_req_i.addr >= COMM_BASE) off = bus_req_i.addr - COMM_BASE;
        else if (bus_req_i.addr >= PSC_BASE) off = bus_req_i.addr - PSC_BASE;
        else if (bus_req_i.addr >= PWM_BASE) off = bus_req_i.addr - PWM_BASE;
        else if (bus_req_i.addr >= SCTRL_BASE) off = bus_req_i.addr - SCTRL_BASE;
        else if (bus_req_i.addr >= CFG_B_BASE) off = bus_req_i.addr - CFG_B_BASE;
        else off = bus_req_i.addr;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= '0;
        end else if (bus_req_i.rd) begin
            rd_data_o <= '0;
            if (bus_req_i.addr < CFG_B_BASE) rd_data_o <= cfg_a_reg[off[2:0]];
            else if (bus_req_i.addr < SCTRL_BASE) rd_data_o <= cfg_b_reg[off[0]];
            else if (bus_req_i.addr < SCTRL_BASE + 8'(SCTRL_BYTES))
                rd_data_o <= sctrl_reg[off[0]];
            else if (bus_req_i.addr >= PWM_BASE && bus_req_i.addr < PWM_BASE + 8'(PWM_BYTES))
                rd_data_o <= pwm_reg[off[2:0]];
            else if (bus_req_i.addr >= PSC_BASE && bus_req_i.addr < PSC_BASE + 8'(PSC_BYTES))
                rd_data_o <= psc_reg[off[0]];
            else if (bus_req_i.addr >= COMM_BASE && bus_req_i.addr < COMM_BASE + 8'(COMM_BYTES))
                rd_data_o <= comm_reg[off[2:0]];
            else if (bus_req_i.addr == STATE_ADDR)
                rd_data_o <= {3'h0, dt_run, wdt_exp, power_state_o};
            else if (bus_req_i.addr == IRQ_STAT_ADDR) rd_data_o <= 8'(irq_stat_reg);
            else if (bus_req_i.addr == IRQ_MASK_ADDR) rd_data_o <= 8'(irq_mask_reg);
        end
    end

    property p_full_sleep;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ev_full |=> (power_state_o == PS_SLEEP && !dis_en_reg && cfg_a_reg[0] == CFG_RST);
    endproperty
    a_full_sleep: assert property (p_full_sleep) else $error("full clear missed");

    property p_long_state;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ev_long && !ev_full) |=> (power_state_o == PS_LONG_DIS && comm_reg[0] == COMM_RST);
    endproperty
    a_long_state: assert property (p_long_state) else $error("long discharge missed");

    property p_thsd_keeps_sctrl;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ev_thsd && !clr_grp && !bus_req_i.wr) |=>
            (!dis_en_reg && sctrl_reg[0] == $past(sctrl_reg[0])) ##1 (s_drive_o == '0);
    endproperty
    a_thsd_keeps_sctrl: assert property (p_thsd_keeps_sctrl) else $error("thsd slip");

    property p_thsd_mute;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ev_thsd && !ev_full && !bus_req_i.wr) |=>
            (cfg_b_reg[1][MUTE_BIT] == $past(cfg_b_reg[1][MUTE_BIT]) && cfg_a_reg[5] == CFG_RST);
    endproperty
    a_thsd_mute: assert property (p_thsd_mute) else $error("mute not kept");

    property p_gpio_nibble;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ev_long && !clr_b0_hi && !bus_req_i.wr) |=>
            (cfg_b_reg[0][GPIO_LSB +: GPIO_W] == '0
             && cfg_b_reg[0][7:4] == $past(cfg_b_reg[0][7:4]));
    endproperty
    a_gpio_nibble: assert property (p_gpio_nibble) else $error("gpio nibble wrong");

    property p_long_monitor;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ev_long && tme && !ev_full && !ev_thsd && !ev_short && !bus_req_i.wr) |=>
            cfg_a_reg[2] == $past(cfg_a_reg[2]);
    endproperty
    a_long_monitor: assert property (p_long_monitor) else $error("A2 cleared");

    property p_short_b0;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ev_short && !ev_full && !ev_thsd && !ev_long && !bus_req_i.wr) |=>
            (cfg_b_reg[0][3:0] == $past(cfg_b_reg[0][3:0]) && cfg_b_reg[0][7:4] == '0
             && cfg_a_reg[4] == CFG_RST && pwm_reg[0] == PWM_RST);
    endproperty
    a_short_b0: assert property (p_short_b0) else $error("short clear wrong");

    property p_short_monitor;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ev_short && tme && !bus_req_i.wr) |=>
            (cfg_a_reg[1] == CFG_RST && cfg_a_reg[3] == CFG_RST);
    endproperty
    a_short_monitor: assert property (p_short_monitor) else $error("A1-A3 kept");

    property p_b1_mute;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ev_short && !ev_full && !bus_req_i.wr) |=>
            (cfg_b_reg[1][MUTE_BIT] == $past(cfg_b_reg[1][MUTE_BIT]) && cfg_b_reg[1][0] == 1'b0);
    endproperty
    a_b1_mute: assert property (p_b1_mute) else $error("B1 clear wrong");
endmodule : rst_evt_clear

/* test/host_keepalive.sv */
// Host-side model that sends valid commands at a steady pace
`timescale 1ns/1ps
module host_keepalive #(
    parameter int GAP = 10
) (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic enable_i,
    output logic      cmd_ok_o
);
    int cnt;

    // Gap well under the watchdog limit, so the device stays awake while enabled
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt      <= 0;
            cmd_ok_o <= 1'b0;
        end else begin
            cnt      <= (cnt == GAP - 1) ? 0 : cnt + 1;
            cmd_ok_o <= enable_i && (cnt == GAP - 1);
        end
    end
endmodule : host_keepalive

/* test/reset_event_register_clearing_bench.sv */
// Self-checking bench for the reset-event clearing block
`timescale 1ns/1ps
module reset_event_register_clearing_bench;
    import rst_evt_pkg::*;
    localparam int WDT = 50;
    logic                 clk_sys_i = 1'b0;
    logic                 sys_rst_i = 1'b1;
    bus_req_s             bus_req   = '0;
    logic                 dt_exp    = 1'b0;
    logic                 thsd      = 1'b0;
    logic                 pin_en    = 1'b0;
    logic                 keep      = 1'b0;
    logic                 cmd_ok;
    logic [7:0]           rd_data;
    power_state_e         pstate;
    logic [NUM_CELLS-1:0] s_drive;
    logic                 wdt_exp;
    logic                 dt_run;
    logic                 irq;
    int                   n_mismatch = 0;
    int                   compares   = 0;
    int                   seed       = 32'h37b4;
    int                   m [0:'h25];
    logic [7:0]           d;

    always #25 clk_sys_i = ~clk_sys_i;

    host_keepalive host_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .enable_i(keep),
                           .cmd_ok_o(cmd_ok));
    rst_evt_clear #(.WDT_LIMIT(WDT)) dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .bus_req_i(bus_req), .cmd_ok_i(cmd_ok), .dt_expire_i(dt_exp), .thsd_pin_i(thsd),
        .discharge_timer_pin_enable_i(pin_en), .rd_data_o(rd_data), .power_state_o(pstate),
        .s_drive_o(s_drive), .wdt_expired_o(wdt_exp), .dt_running_o(dt_run), .irq_o(irq));

    function automatic bit mapped(input int a);
        return a < 'h0a || (a >= 'h10 && a < 'h1a) || (a >= 'h20 && a < 'h26);
    endfunction : mapped

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One strobe cycle, then one idle cycle, so strobes never get two drives at one edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        bus_req <= '{wr: w, rd: !w, addr: a, wdata: v};
        @(posedge clk_sys_i);
        bus_req <= '0;
        #1;
        d = rd_data;
        if (w && mapped(int'(a))) m[a] = int'(v);
    endtask : bus

    task automatic cmp_all;
        for (int a = 0; a < 'h26; a++) begin
            bus(1'b0, 8'(a), 8'h00);
            chk(16'(d), mapped(a) ? 16'(m[a]) : 16'h0000);
        end
    endtask : cmp_all

    // Model of the clearing: 0 thermal, 1 watchdog with timer, 2 full sleep, 3 timer first
    task automatic ev_clear(input int k);
        int mute;
        mute = m[7] & 'h02;
        if (k != 3) for (int i = 'h20; i < 'h26; i++) m[i] = 'hff;
        if (k == 0 || k == 2) for (int i = 0; i < 8; i++) m[i] = 0;
        if ((k == 1 && (m[7] & 8) == 0) || (k == 3 && (m[7] & 8) != 0))
            for (int i = 1; i < 4; i++) m[i] = 0;
        if (k == 0 || k == 3) m[7] = mute;
        if (k == 1) m[0] = 0;
        if (k == 1) m[6] = m[6] & 'hf0;
        if (k == 3) m[6] = m[6] & 'h0f;
        if (k == 3) m[4] = 0;
        if (k == 3) m[5] = 0;
        if (k >= 2) for (int i = 'h08; i < 'h1a; i++) if (mapped(i)) m[i] = (i < 'h10) ? 0 : 'hff;
    endtask : ev_clear

    task automatic fill(input logic [7:0] b1, input logic [7:0] mask);
        for (int a = 0; a < 'h26; a++) if (mapped(a)) bus(1'b1, 8'(a), 8'($random(seed)));
        bus(1'b1, 8'h05, 8'h30 | 8'($random(seed) & 'h0f));
        bus(1'b1, 8'h07, b1);
        bus(1'b1, IRQ_MASK_ADDR, mask);
        repeat (3) @(posedge clk_sys_i);
    endtask : fill

    task automatic pulse_dt;
        @(posedge clk_sys_i);
        dt_exp <= 1'b1;
        @(posedge clk_sys_i);
        dt_exp <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask : pulse_dt

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    initial begin
        #(50 * 20000);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        for (int a = 0; a < 'h26; a++) m[a] = (a >= 'h10 && mapped(a)) ? 'hff : 0;
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        keep      <= 1'b1;
        cmp_all();
        chk(16'(pstate), 16'(PS_STANDBY));
        chk(16'(s_drive), 16'h0000);
        fill(8'h02, 8'h07);
        pin_en <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        chk(16'(dt_run), 16'h0001);
        chk(16'(s_drive), 16'({m[9][6:0], m[8][7:0]}));
        thsd <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        ev_clear(0);
        chk(16'(s_drive), 16'h0000);
        chk(16'(irq), 16'h0001);
        cmp_all();
        bus(1'b0, IRQ_STAT_ADDR, 8'h00);
        chk(16'(d), 16'h0001);
        thsd <= 1'b0;
        // Watchdog expiry while the discharge timer runs, monitor disabled
        fill(8'h02, 8'h07);
        keep <= 1'b0;
        repeat (WDT + 8) @(posedge clk_sys_i);
        ev_clear(1);
        chk(16'(pstate), 16'(PS_LONG_DIS));
        chk(16'(wdt_exp), 16'h0001);
        bus(1'b0, STATE_ADDR, 8'h00);
        chk(16'(d), 16'({2'b11, PS_LONG_DIS}));
        chk(16'(s_drive), 16'({m[9][6:0], m[8][7:0]}));
        cmp_all();
        bus(1'b0, IRQ_STAT_ADDR, 8'h00);
        chk(16'(d), 16'h0002);
        pulse_dt();
        ev_clear(2);
        chk(16'(pstate), 16'(PS_SLEEP));
        chk(16'(s_drive), 16'h0000);
        cmp_all();
        bus(1'b0, IRQ_STAT_ADDR, 8'h00);
        chk(16'(d), 16'h0004);
        keep <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        chk(16'(pstate), 16'(PS_STANDBY));
        chk(16'(wdt_exp), 16'h0000);
        // Timer expiry before the watchdog, monitor enabled, timer interrupt masked
        fill(8'h0a, 8'h03);
        pulse_dt();
        ev_clear(3);
        chk(16'(s_drive), 16'h0000);
        chk(16'(irq), 16'h0000);
        chk(16'(dt_run), 16'h0000);
        cmp_all();
        bus(1'b0, IRQ_STAT_ADDR, 8'h00);
        chk(16'(d), 16'h0004);
        bus(1'b0, IRQ_MASK_ADDR, 8'h00);
        chk(16'(d), 16'h0003);
        // Watchdog expiry with the timer pin low
        fill(8'h0a, 8'h07);
        pin_en <= 1'b0;
        keep   <= 1'b0;
        repeat (WDT + 8) @(posedge clk_sys_i);
        ev_clear(2);
        chk(16'(pstate), 16'(PS_SLEEP));
        chk(16'(s_drive), 16'h0000);
        cmp_all();
        // Watchdog expiry while the timer runs, monitor enabled: A1-A3 kept
        keep   <= 1'b1;
        pin_en <= 1'b1;
        fill(8'h0a, 8'h07);
        keep <= 1'b0;
        repeat (WDT + 8) @(posedge clk_sys_i);
        ev_clear(1);
        chk(16'(pstate), 16'(PS_LONG_DIS));
        cmp_all();
        report_and_stop();
    end
endmodule : reset_event_register_clearing_bench
